/* logic/nibble_exec.sv */
// Execute stage: accumulator, flags, program counter and write-back strobes
`timescale 1ns/1ns
module nibble_exec
   import nibble_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic                     instr_valid,
   input  wire logic [15:0]              instr,
   input  wire logic [DW-1:0]            wr_rdata,
   input  wire logic [DW-1:0]            mem_rdata,
   output logic [WRW-1:0]                wr_raddr,
   output logic [MAW-1:0]                mem_raddr,
   output logic [DW-1:0]                 accumulator_nibble,
   output logic                          carry_flag_bit,
   output logic                          zero_flag_bit,
   output logic [PCW-1:0]                program_counter,
   output logic                          wr_we,
   output logic [WRW-1:0]                wr_waddr,
   output logic [DW-1:0]                 wr_wdata,
   output logic                          mem_we,
   output logic [MAW-1:0]                mem_waddr,
   output logic [DW-1:0]                 mem_wdata,
   output logic                          push_we,
   output logic [PCW-1:0]                push_data
);
   import nibble_pkg::*;

   op_bus_if ob ();
   op_decode u_dec (.instr(instr), .ob(ob));

   // Read addresses are combinational so operands arrive in the same cycle
   assign wr_raddr  = ob.wsel;
   assign mem_raddr = ob.maddr;

   logic [DW-1:0]  acc_reg, acc_next, res;
   logic           cf_reg, cf_next, zf_reg, zf_next;
   logic [PCW-1:0] pc_reg, pc_next;
   logic           wwe_next, mwe_next, pwe_next;
   logic [WRW-1:0] wwa_next;
   logic [MAW-1:0] mwa_next;
   logic [DW-1:0]  wd_next;
   logic [PCW-1:0] pd_next;
   logic           upd_z;

   always_comb begin
      acc_next = acc_reg;
      cf_next  = cf_reg;
      zf_next  = zf_reg;
      pc_next  = pc_reg;
      wwe_next = 1'b0;
      mwe_next = 1'b0;
      pwe_next = 1'b0;
      wwa_next = ob.wsel;
      mwa_next = ob.maddr;
      pd_next  = pc_reg + PC_ONE;
      res      = acc_reg;
      upd_z    = 1'b0;
      if (instr_valid) begin
         pc_next = pc_reg + PC_ONE;
         unique case (ob.op)
            OP_ADU_WR:  begin res = wr_rdata + ob.imm; upd_z = 1'b1; end
            OP_ADD_KEEP_CARRY_WRITE_BACK_WR: begin res = wr_rdata + ob.imm; upd_z = 1'b1;
                              wwe_next = 1'b1; end
            OP_ANL_WR:  begin res = wr_rdata & ob.imm; upd_z = 1'b1; end
            OP_AND_WRITE_BACK_WR: begin res = wr_rdata & ob.imm; upd_z = 1'b1;
                              wwe_next = 1'b1; end
            OP_ADD_KEEP_CARRY_WRITE_BACK_M:  begin res = mem_rdata + acc_reg; upd_z = 1'b1;
                              mwe_next = 1'b1; end
            OP_ANL_M:   begin res = mem_rdata & acc_reg; upd_z = 1'b1; end
            OP_AND_WRITE_BACK_M:  begin res = mem_rdata & acc_reg; upd_z = 1'b1;
                              mwe_next = 1'b1; end
            OP_DO_CALL: begin pwe_next = 1'b1; pc_next = ob.target; end
            OP_DO_CLRCF: cf_next = 1'b0;
            OP_NONE:    ;
         endcase
         if (upd_z) begin
            acc_next = res;
            zf_next  = (res == ACC_RST);
         end
      end
      wd_next = res;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         acc_reg <= ACC_RST; cf_reg <= 1'b0; zf_reg <= 1'b0; pc_reg <= PC_RST;
         wr_we <= 1'b0; mem_we <= 1'b0; push_we <= 1'b0;
         wr_waddr <= '0; mem_waddr <= '0; wr_wdata <= ACC_RST; mem_wdata <= ACC_RST;
         push_data <= PC_RST;
      end else begin
         acc_reg <= acc_next; cf_reg <= cf_next; zf_reg <= zf_next; pc_reg <= pc_next;
         wr_we <= wwe_next; mem_we <= mwe_next; push_we <= pwe_next;
         wr_waddr <= wwa_next; mem_waddr <= mwa_next;
         wr_wdata <= wd_next; mem_wdata <= wd_next; push_data <= pd_next;
      end
   end

   assign accumulator_nibble = acc_reg;
   assign carry_flag_bit     = cf_reg;
   assign zero_flag_bit      = zf_reg;
   assign program_counter    = pc_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   clrcf_zero_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr == OP_CLR_CF |=> !carry_flag_bit && $stable(zero_flag_bit))
      else $error("carry not cleared");
   call_push_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:11] == OP_CALL |=> push_we &&
      program_counter == $past(instr[PCW-1:0]) && push_data == $past(pc_reg) + PC_ONE)
      else $error("call wrong");
   adu_wr_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:8] == OP_ADD_WR |=> !wr_we && $stable(carry_flag_bit) &&
      accumulator_nibble == DW'($past(wr_rdata) + $past(instr[7:4])))
      else $error("add wr wrong");
   add_keep_carry_write_back_m_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:7] == OP_ADD_M |=> mem_we && mem_wdata == accumulator_nibble
      && mem_waddr == $past(instr[MAW-1:0]))
      else $error("add mem wrong");
   add_keep_carry_write_back_wr_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:8] == OP_ADDR_WR |=> wr_we && wr_wdata == accumulator_nibble)
      else $error("add wb wrong");
   anl_m_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:7] == OP_AND_M |=> !mem_we &&
      accumulator_nibble == ($past(mem_rdata) & $past(acc_reg)))
      else $error("and mem wrong");
   anl_wr_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:8] == OP_AND_WR |=> !wr_we &&
      accumulator_nibble == ($past(wr_rdata) & $past(instr[7:4])))
      else $error("and wr wrong");
   and_write_back_m_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:7] == OP_ANDR_M |=> mem_we && $stable(carry_flag_bit))
      else $error("and mem wb wrong");
   and_write_back_wr_a: assert property (@(posedge mclk) disable iff (rst)
      instr_valid && instr[15:8] == OP_ANDR_WR |=> wr_we && wr_waddr == $past(instr[3:0]))
      else $error("and wr wb wrong");
   zero_flag_a: assert property (@(posedge mclk) disable iff (rst)
      $past(upd_z) |-> zero_flag_bit == (accumulator_nibble == ACC_RST))
      else $error("zero flag wrong");
endmodule

/* logic/nibble_pkg.sv */
// Package with opcode patterns, widths and reset values for the nibble decoder
// What this block does
// - Acc gets working register plus immediate
// - Acc and memory get memory plus acc
// - Working register and acc get sum
// - Acc gets memory AND acc
// - Acc gets working register AND immediate
// - Memory and acc get memory AND acc
// - Working register and acc get AND
// - Call pushes next counter, loads target
// - Clear carry instruction clears carry only
package nibble_pkg;
   localparam int DW = 4;
   localparam int MAW = 7;
   localparam int PCW = 11;
   localparam int WRW = 4;
   localparam logic [7:0] OP_ADD_WR  = 8'h2C;
   localparam logic [7:0] OP_ADDR_WR = 8'h2D;
   localparam logic [7:0] OP_AND_WR  = 8'h2E;
   localparam logic [7:0] OP_ANDR_WR = 8'h2F;
   localparam logic [8:0] OP_ADD_M   = 9'h052;
   localparam logic [8:0] OP_AND_M   = 9'h054;
   localparam logic [8:0] OP_ANDR_M  = 9'h056;
   localparam logic [4:0] OP_CALL    = 5'h0C;
   localparam logic [15:0] OP_CLR_CF = 16'h5000;
   localparam logic [DW-1:0]  ACC_RST = 4'h0;
   localparam logic [PCW-1:0] PC_RST  = 11'h000;
   localparam logic [PCW-1:0] PC_ONE  = 11'h001;
   typedef enum {OP_NONE, OP_ADU_WR, OP_ADD_KEEP_CARRY_WRITE_BACK_WR, OP_ANL_WR, OP_AND_WRITE_BACK_WR,
                 OP_ADD_KEEP_CARRY_WRITE_BACK_M, OP_ANL_M, OP_AND_WRITE_BACK_M, OP_DO_CALL, OP_DO_CLRCF} op_t;
endpackage

/* logic/op_bus_if.sv */
// Interface carrying the decoded operation and its fields
`timescale 1ns/1ns
interface op_bus_if;
   import nibble_pkg::*;
   op_t            op;
   logic [DW-1:0]  imm;
   logic [WRW-1:0] wsel;
   logic [MAW-1:0] maddr;
   logic [PCW-1:0] target;
   modport dec (output op, imm, wsel, maddr, target);
   modport exe (input op, imm, wsel, maddr, target);
endinterface

/* logic/op_decode.sv */
// Combinational decoder of the instruction word
`timescale 1ns/1ns
module op_decode
   import nibble_pkg::*;
(
   input  wire logic [15:0] instr,
   op_bus_if.dec            ob
);
   always_comb begin
      ob.imm    = instr[7:4];
      ob.wsel   = instr[3:0];
      ob.maddr  = instr[MAW-1:0];
      ob.target = instr[PCW-1:0];
      ob.op     = OP_NONE;
      if (instr[15:8] == OP_ADD_WR) ob.op = OP_ADU_WR;
      else if (instr[15:8] == OP_ADDR_WR) ob.op = OP_ADD_KEEP_CARRY_WRITE_BACK_WR;
      else if (instr[15:8] == OP_AND_WR) ob.op = OP_ANL_WR;
      else if (instr[15:8] == OP_ANDR_WR) ob.op = OP_AND_WRITE_BACK_WR;
      else if (instr[15:7] == OP_ADD_M) ob.op = OP_ADD_KEEP_CARRY_WRITE_BACK_M;
      else if (instr[15:7] == OP_AND_M) ob.op = OP_ANL_M;
      else if (instr[15:7] == OP_ANDR_M) ob.op = OP_AND_WRITE_BACK_M;
      else if (instr[15:11] == OP_CALL) ob.op = OP_DO_CALL;
      else if (instr == OP_CLR_CF) ob.op = OP_DO_CLRCF;
   end
endmodule

/* tb/tb.sv */
// Self-checking testbench for the nibble add, AND, call and clear-carry execute stage
`timescale 1ns/1ns
module tb;
   import nibble_pkg::*;
   logic           mclk, rst, instr_valid;
   logic [15:0]    instr;
   logic [DW-1:0]  wr_rdata, mem_rdata, accumulator_nibble, wr_wdata, mem_wdata;
   logic [WRW-1:0] wr_raddr, wr_waddr;
   logic [MAW-1:0] mem_raddr, mem_waddr;
   logic [PCW-1:0] program_counter, push_data, pc_exp;
   logic           carry_flag_bit, zero_flag_bit, wr_we, mem_we, push_we;
   int             num_errors, tests_run, cycles;

   nibble_exec dut (.mclk(mclk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .wr_rdata(wr_rdata), .mem_rdata(mem_rdata), .wr_raddr(wr_raddr),
      .mem_raddr(mem_raddr), .accumulator_nibble(accumulator_nibble),
      .carry_flag_bit(carry_flag_bit), .zero_flag_bit(zero_flag_bit),
      .program_counter(program_counter), .wr_we(wr_we), .wr_waddr(wr_waddr),
      .wr_wdata(wr_wdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
      .mem_wdata(mem_wdata), .push_we(push_we), .push_data(push_data));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   // One instruction; results land on the taking edge, one edge after the drive edge
   task automatic run_op(input logic [15:0] i, input logic [3:0] w, input logic [3:0] m,
                         input logic [3:0] ea, input logic ez, input logic ww,
                         input logic mw);
      logic [10:0] pn;
      logic        pw;
      pw = (i[15:11] === OP_CALL);
      pn = pw ? i[10:0] : pc_exp + 11'h001;
      @(posedge mclk);
      instr <= i;
      instr_valid <= 1'b1;
      wr_rdata <= w;
      mem_rdata <= m;
      #1;
      chk("wr_raddr", i[3:0], wr_raddr);
      chk("mem_raddr", i[6:0], mem_raddr);
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      chk("acc", ea, accumulator_nibble);
      chk("zero", ez, zero_flag_bit);
      chk("carry", 11'h000, carry_flag_bit);
      chk("pc", pn, program_counter);
      chk("wr_we", ww, wr_we);
      chk("mem_we", mw, mem_we);
      chk("push_we", pw, push_we);
      if (ww) chk("wr_waddr", i[3:0], wr_waddr);
      if (ww) chk("wr_wdata", ea, wr_wdata);
      if (mw) chk("mem_waddr", i[6:0], mem_waddr);
      if (mw) chk("mem_wdata", ea, mem_wdata);
      if (pw) chk("push_data", pc_exp + 11'h001, push_data);
      pc_exp = pn;
   endtask

   task automatic t_reset();
      chk("acc", 11'h000, accumulator_nibble);
      chk("zero", 11'h000, zero_flag_bit);
      chk("pc", 11'h000, program_counter);
      chk("strobes", 11'h000, {wr_we, mem_we, push_we});
      pc_exp = 11'h000;
   endtask

   task automatic t_add();
      run_op(16'h2C35, 4'hD, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
      run_op(16'h2955, 4'h0, 4'h7, 4'h7, 1'b0, 1'b0, 1'b1);
      run_op(16'h2D9A, 4'h4, 4'h0, 4'hD, 1'b0, 1'b1, 1'b0);
   endtask

   task automatic t_and();
      run_op(16'h2A12, 4'h0, 4'h6, 4'h4, 1'b0, 1'b0, 1'b0);
      run_op(16'h2E30, 4'hC, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
      run_op(16'h2F7B, 4'hE, 4'h0, 4'h6, 1'b0, 1'b1, 1'b0);
      run_op(16'h2B7F, 4'h0, 4'h3, 4'h2, 1'b0, 1'b0, 1'b1);
   endtask

   task automatic t_call();
      run_op(16'h6123, 4'h5, 4'h5, 4'h2, 1'b0, 1'b0, 1'b0);
      run_op(16'h67FF, 4'h5, 4'h5, 4'h2, 1'b0, 1'b0, 1'b0);
   endtask

   // Zero flag set first so that an unwanted flag write would show
   task automatic t_clear();
      run_op(16'h2E00, 4'hF, 4'h0, 4'h0, 1'b1, 1'b0, 1'b0);
      run_op(16'h5000, 4'h9, 4'h9, 4'h0, 1'b1, 1'b0, 1'b0);
      run_op(16'h5001, 4'h9, 4'h9, 4'h0, 1'b1, 1'b0, 1'b0);
   endtask

   initial begin
      rst = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0000;
      wr_rdata = 4'h0;
      mem_rdata = 4'h0;
      repeat (2) @(posedge mclk);
      #1;
      t_reset();
      @(posedge mclk);
      rst <= 1'b0;
      t_add();
      t_and();
      t_call();
      t_clear();
      print_verdict();
   end

   // Whole run needs well under a hundred cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         print_verdict();
      end
   end
endmodule
